// ===== common/interval_timekeeper_pkg.sv
// Shared constants for the interval timekeeper and its register bus slave.
package interval_timekeeper_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS        = 100;
    localparam int unsigned FRACTION_STEP_NS     = 7812500;
    localparam int unsigned FRACTION_STEP_CYCLES =
        FRACTION_STEP_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_CONTROL   = 32'h0000_0000;
    localparam logic [31:0] ADDR_FRACTION  = 32'h0000_0004;
    localparam logic [31:0] ADDR_SECONDS   = 32'h0000_0008;
    localparam logic [31:0] ADDR_MINUTES   = 32'h0000_000C;
    localparam logic [31:0] ADDR_HOURS     = 32'h0000_0010;
    localparam logic [31:0] ADDR_TARGET    = 32'h0000_0014;
    localparam logic [31:0] ADDR_INTERVAL  = 32'h0000_0018;
    localparam logic [31:0] ADDR_IRQ_STAT  = 32'h0000_001C;
    localparam logic [31:0] ADDR_IRQ_MASK  = 32'h0000_0020;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int unsigned CTL_RESERVED   = 7;
    localparam int unsigned CTL_DAY_WRAP   = 6;
    localparam int unsigned CTL_TB_HI      = 5;
    localparam int unsigned CTL_TB_LO      = 4;
    localparam int unsigned CTL_ONE_SHOT   = 3;
    localparam int unsigned CTL_MATCH      = 2;
    localparam int unsigned CTL_IEN        = 1;
    localparam int unsigned CTL_TCE        = 0;
    localparam logic [7:0]  CTL_RESET      = 8'h00;

    // ------------------------------------------------------------------
    // Counter limits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  FRACTION_MAX   = 8'h7F;
    localparam logic [7:0]  SECMIN_MAX     = 8'h3B;
    localparam logic [7:0]  HOUR_DAY_MAX   = 8'h17;
    localparam logic [7:0]  HOUR_FULL_MAX  = 8'hFF;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Interrupt status and mask fields
    // ------------------------------------------------------------------
    localparam int unsigned IRQ_MATCH      = 0;
    localparam int unsigned IRQ_SECOND     = 1;
    localparam int unsigned IRQ_W          = 2;

    typedef enum logic [1:0] {
        TB_FRACTION = 2'b00,
        TB_SECONDS  = 2'b01,
        TB_MINUTES  = 2'b10,
        TB_HOURS    = 2'b11
    } timebase_t;

endpackage

// ===== verilog/wrap_counter.sv
// Loadable 8-bit wrapping counter used for each time register.
`timescale 1ns/1ns
`default_nettype none

module wrap_counter
    import interval_timekeeper_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clr,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic       inc,
    input  wire logic [7:0] max_val,
    output logic      [7:0] count,
    output logic            wrap
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Wrap on reaching or passing the limit, so a value above a newly
    // lowered limit still returns to zero at the next step.
    assign wrap = inc && (count >= max_val);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= COUNT_RESET;
        end else if (clr) begin
            count <= COUNT_RESET;
        end else if (load) begin
            count <= load_val;
        end else if (wrap) begin
            count <= COUNT_RESET;
        end else if (inc) begin
            count <= count + 8'h01;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/interval_timekeeper.sv
// Interval timekeeper: time registers, interval counter and bus slave.
`timescale 1ns/1ns
`default_nettype none

module interval_timekeeper
    import interval_timekeeper_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FRACTION_STEP_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        por_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             wake
);

    localparam int PRE_W = $clog2(TICK_CYCLES);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0]      addr_ff;
    logic             wr_ff;
    logic             accept;
    logic [7:0]       rd_data;
    logic             we_ctl;
    logic             we_frac;
    logic             we_sec;
    logic             we_min;
    logic             we_hour;
    logic             we_target;
    logic             we_mask;
    logic [7:0]       wdata;

    logic             day_wrap_select_ff;
    timebase_t        timebase_ff;
    logic             one_shot_select_ff;
    logic             match_flag_ff;
    logic             interval_count_enable_ff;
    logic             time_clock_enable_ff;
    logic [7:0]       interval_target_ff;
    logic [7:0]       interval_count_ff;
    logic [7:0]       nxt_interval_count;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] irq_set;

    logic [PRE_W-1:0] pre_ff;
    logic             frac_step;
    logic             time_clr;
    logic [7:0]       hour_max;
    logic [7:0]       fraction_tally;
    logic [7:0]       seconds_count;
    logic [7:0]       minutes_count;
    logic [7:0]       hours_count;
    logic             frac_wrap;
    logic             sec_wrap;
    logic             min_wrap;
    logic             tb_tick;
    logic             timeout;

    // ------------------------------------------------------------------
    // AHB-Lite address and data phase
    // ------------------------------------------------------------------
    assign accept = hsel && hready && htrans[1];
    assign wdata  = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 32'h0000_0000;
            wr_ff   <= 1'b0;
        end else begin
            addr_ff <= accept ? haddr : addr_ff;
            wr_ff   <= accept && hwrite;
        end
    end

    always_comb begin
        we_ctl    = 1'b0;
        we_frac   = 1'b0;
        we_sec    = 1'b0;
        we_min    = 1'b0;
        we_hour   = 1'b0;
        we_target = 1'b0;
        we_mask   = 1'b0;
        if (!wr_ff) begin
            we_ctl = 1'b0;
        end else if (addr_ff == ADDR_CONTROL) begin
            we_ctl = 1'b1;
        end else if (addr_ff == ADDR_FRACTION) begin
            we_frac = 1'b1;
        end else if (addr_ff == ADDR_SECONDS) begin
            we_sec = 1'b1;
        end else if (addr_ff == ADDR_MINUTES) begin
            we_min = 1'b1;
        end else if (addr_ff == ADDR_HOURS) begin
            we_hour = 1'b1;
        end else if (addr_ff == ADDR_TARGET) begin
            we_target = 1'b1;
        end else if (addr_ff == ADDR_IRQ_MASK) begin
            we_mask = 1'b1;
        end
    end

    // Read data is formed in the address phase so hrdata leaves a flop.
    // The price is that a read right behind a write to the same register
    // returns the value from before that write.
    always_comb begin
        rd_data = 8'h00;
        if (haddr == ADDR_CONTROL) begin
            rd_data = {1'b0, day_wrap_select_ff, timebase_ff,
                       one_shot_select_ff, match_flag_ff,
                       interval_count_enable_ff,
                       time_clock_enable_ff};
        end else if (haddr == ADDR_FRACTION) begin
            rd_data = fraction_tally;
        end else if (haddr == ADDR_SECONDS) begin
            rd_data = seconds_count;
        end else if (haddr == ADDR_MINUTES) begin
            rd_data = minutes_count;
        end else if (haddr == ADDR_HOURS) begin
            rd_data = hours_count;
        end else if (haddr == ADDR_TARGET) begin
            rd_data = interval_target_ff;
        end else if (haddr == ADDR_INTERVAL) begin
            rd_data = interval_count_ff;
        end else if (haddr == ADDR_IRQ_STAT) begin
            rd_data = {{(8 - IRQ_W){1'b0}}, irq_status_ff};
        end else if (haddr == ADDR_IRQ_MASK) begin
            rd_data = {{(8 - IRQ_W){1'b0}}, irq_mask_ff};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (accept && !hwrite) ? {24'h00_0000, rd_data}
                                             : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Only the day-wrap bit follows the bus reset; everything that keeps
    // time lives on the power-on reset so a bus reset does not stop it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            day_wrap_select_ff <= CTL_RESET[CTL_DAY_WRAP];
        end else if (we_ctl) begin
            day_wrap_select_ff <= wdata[CTL_DAY_WRAP];
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            timebase_ff          <= timebase_t'(CTL_RESET[CTL_TB_HI -: 2]);
            one_shot_select_ff   <= CTL_RESET[CTL_ONE_SHOT];
            time_clock_enable_ff <= CTL_RESET[CTL_TCE];
        end else if (we_ctl) begin
            timebase_ff          <= timebase_t'(wdata[CTL_TB_HI:CTL_TB_LO]);
            one_shot_select_ff   <= wdata[CTL_ONE_SHOT];
            time_clock_enable_ff <= wdata[CTL_TCE];
        end
    end

    // A timeout in the same cycle as a software clear keeps the flag.
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            match_flag_ff <= CTL_RESET[CTL_MATCH];
        end else if (we_ctl) begin
            match_flag_ff <= timeout ||
                             (match_flag_ff && wdata[CTL_MATCH]);
        end else if (timeout) begin
            match_flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            interval_count_enable_ff <= CTL_RESET[CTL_IEN];
        end else if (we_ctl) begin
            interval_count_enable_ff <= wdata[CTL_IEN] &&
                !(timeout && one_shot_select_ff);
        end else if (timeout && one_shot_select_ff) begin
            interval_count_enable_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            interval_target_ff <= COUNT_RESET;
        end else if (we_target) begin
            interval_target_ff <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // Fraction step prescaler
    // ------------------------------------------------------------------
    assign frac_step = time_clock_enable_ff &&
                       (pre_ff == PRE_W'(TICK_CYCLES - 1));

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            pre_ff <= '0;
        end else if (!time_clock_enable_ff || frac_step) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + PRE_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Time registers
    // ------------------------------------------------------------------
    assign time_clr = we_ctl && time_clock_enable_ff &&
                      !wdata[CTL_TCE];
    assign hour_max = day_wrap_select_ff ? HOUR_DAY_MAX
                                         : HOUR_FULL_MAX;

    wrap_counter u_fraction (
        .clk      (hclk),
        .rst_n    (por_n),
        .clr      (time_clr),
        .load     (we_frac && !time_clock_enable_ff),
        .load_val (wdata),
        .inc      (frac_step),
        .max_val  (FRACTION_MAX),
        .count    (fraction_tally),
        .wrap     (frac_wrap)
    );

    wrap_counter u_seconds (
        .clk      (hclk),
        .rst_n    (por_n),
        .clr      (time_clr),
        .load     (we_sec && !time_clock_enable_ff),
        .load_val (wdata),
        .inc      (frac_wrap),
        .max_val  (SECMIN_MAX),
        .count    (seconds_count),
        .wrap     (sec_wrap)
    );

    wrap_counter u_minutes (
        .clk      (hclk),
        .rst_n    (por_n),
        .clr      (time_clr),
        .load     (we_min && !time_clock_enable_ff),
        .load_val (wdata),
        .inc      (sec_wrap),
        .max_val  (SECMIN_MAX),
        .count    (minutes_count),
        .wrap     (min_wrap)
    );

    wrap_counter u_hours (
        .clk      (hclk),
        .rst_n    (por_n),
        .clr      (time_clr),
        .load     (we_hour && !time_clock_enable_ff),
        .load_val (wdata),
        .inc      (min_wrap),
        .max_val  (hour_max),
        .count    (hours_count),
        .wrap     ()
    );

    // ------------------------------------------------------------------
    // Interval counter
    // ------------------------------------------------------------------
    always_comb begin
        case (timebase_ff)
            TB_FRACTION: tb_tick = frac_step;
            TB_SECONDS:  tb_tick = frac_wrap;
            TB_MINUTES:  tb_tick = sec_wrap;
            TB_HOURS:    tb_tick = min_wrap;
            default:     tb_tick = 1'b0;
        endcase
    end

    // After a match the next tick returns the count to zero.
    assign nxt_interval_count = (interval_count_ff == interval_target_ff)
                              ? COUNT_RESET
                              : interval_count_ff + 8'h01;
    assign timeout = interval_count_enable_ff && tb_tick &&
                     (nxt_interval_count == interval_target_ff);

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            interval_count_ff <= COUNT_RESET;
        end else if (!interval_count_enable_ff) begin
            interval_count_ff <= COUNT_RESET;
        end else if (tb_tick) begin
            interval_count_ff <= nxt_interval_count;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and outputs
    // ------------------------------------------------------------------
    always_comb begin
        irq_set             = '0;
        irq_set[IRQ_MATCH]  = timeout;
        irq_set[IRQ_SECOND] = frac_wrap;
    end

    // A status read clears the sticky bits, but an event in that same
    // cycle is kept.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_ff <= '0;
        end else if (accept && !hwrite && haddr == ADDR_IRQ_STAT) begin
            irq_status_ff <= irq_set;
        end else begin
            irq_status_ff <= irq_status_ff | irq_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_ff <= '0;
        end else if (we_mask) begin
            irq_mask_ff <= wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= |(irq_status_ff & irq_mask_ff);
            wake <= match_flag_ff && irq_mask_ff[IRQ_MATCH];
        end
    end

endmodule

`default_nettype wire

// ===== verif/interval_timekeeper_assertions.sv
// Concurrent checks on the interval timekeeper bus and interrupt ports.
`timescale 1ns/1ns
`default_nettype none

module interval_timekeeper_assertions
    import interval_timekeeper_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FRACTION_STEP_CYCLES
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        por_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        wake
);
    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    wire logic        take;
    logic             rd_ff;
    logic             wr_ff;
    logic [31:0]      wa_ff;
    logic [IRQ_W-1:0] mask_ff;

    assign take = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            wa_ff <= 32'h0000_0000;
        end else begin
            rd_ff <= take & ~hwrite;
            wr_ff <= take & hwrite;
            wa_ff <= haddr;
        end
    end

    // Mirrors the mask register, so both interrupt outputs can be held
    // against it without looking inside the design.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_ff <= '0;
        end else if (wr_ff && wa_ff == ADDR_IRQ_MASK) begin
            mask_ff <= hwdata[IRQ_W-1:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd(a);
        take && !hwrite && haddr == a;
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low after reset");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not OKAY");
    a_rdata_idle: assert property (!rd_ff |-> hrdata == 32'h0000_0000)
        else $error("hrdata nonzero outside read data phase");
    a_rdata_upper: assert property (take && !hwrite |=> hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits nonzero");
    a_reserved_zero: assert property (
        s_rd(ADDR_CONTROL) |=> !hrdata[7])
        else $error("reserved control bit reads one");
    a_fraction_range: assert property (
        s_rd(ADDR_FRACTION) |=> hrdata[7:0] <= FRACTION_MAX)
        else $error("fraction above its limit");
    a_secmin_range: assert property (
        s_rd(ADDR_SECONDS) or s_rd(ADDR_MINUTES) |=> hrdata[7:0] <= SECMIN_MAX)
        else $error("seconds or minutes above limit");
    a_wake_masked: assert property (
        wake |-> $past(mask_ff[IRQ_MATCH]))
        else $error("wake raised with match interrupt masked");
    a_irq_masked: assert property (
        irq |-> $past(mask_ff) != '0)
        else $error("irq raised with every interrupt masked");
endmodule

bind interval_timekeeper interval_timekeeper_assertions #(
    .TICK_CYCLES(TICK_CYCLES)
) i_chk (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wake(wake)
);

`default_nettype wire

// ===== verif/interval_timekeeper_tb.sv
// Self-checking testbench for the interval timekeeper.
`timescale 1ns/1ns
`default_nettype none

module interval_timekeeper_tb
    import interval_timekeeper_pkg::*;
;
    localparam int unsigned TICK = 4;
    logic        hclk, hresetn, por_n, hsel, hwrite, rd_dp;
    logic [31:0] haddr, hwdata, v, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire logic   hready;
    logic        hreadyout, hresp, irq, wake;
    logic [63:0] ent;
    logic [63:0] q[$];
    int          failures, checked, seed, i;
    logic [31:0] ta[4] = '{ADDR_FRACTION, ADDR_SECONDS,
                           ADDR_MINUTES, ADDR_HOURS};
    logic [7:0]  tm[4] = '{FRACTION_MAX, SECMIN_MAX,
                           SECMIN_MAX, HOUR_FULL_MAX};

    assign hready = hreadyout;

    interval_timekeeper #(.TICK_CYCLES(TICK)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wake(wake)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d, e, m);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= ~w;
        if (!w) q.push_back({m, e & m});
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask

    task automatic rd(input logic [31:0] a, e, m);
        bus(1'b0, a, 32'h0, e, m);
    endtask

    // The pin is read after the wait, not when the task is called.
    task automatic flag(input logic pick_wake, input logic exp);
        repeat (3) @(posedge hclk);
        cmp({31'h0, (pick_wake ? wake : irq)}, {31'h0, exp});
    endtask

    // Read data is judged at the edge that ends its data phase.
    always @(posedge hclk) begin
        if (rd_dp) begin
            ent = q.pop_front();
            cmp(hrdata & ent[63:32], ent[31:0]);
        end
    end

    task automatic end_sim;
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        end_sim;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {hsel, hwrite, rd_dp, hresetn, por_n} = 5'h00;
        {haddr, hwdata, htrans, failures, checked} = '0;
        hsize = 3'b010;
        seed = 32'h9981;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        rd(ADDR_CONTROL, 32'h0, 32'hFFFF_FFFF);
        rd(ADDR_TARGET, 32'h0, 32'hFFFF_FFFF);
        rd(32'h0000_0040, 32'h0, 32'hFFFF_FFFF);
        wr(ADDR_CONTROL, 32'h80);
        rd(ADDR_CONTROL, 32'h0, 32'h80);
        v = $random(seed) & 32'hFF;
        wr(ADDR_TARGET, v);
        rd(ADDR_TARGET, v, 32'hFF);
        for (i = 0; i < 4; i++) begin
            v = $random(seed) & {24'h0, tm[i]};
            wr(ta[i], v);
            rd(ta[i], v, 32'hFF);
            wr(ta[i], {24'h0, tm[i]});
        end
        // Hours sit at HOUR_DAY_MAX in both hour modes; only the day mode wraps them to zero.
        wr(ADDR_HOURS, {24'h0, HOUR_DAY_MAX});
        wr(ADDR_CONTROL, 32'h01);
        repeat (20) @(posedge hclk);
        rd(ADDR_HOURS, 32'h18, 32'hFF);
        rd(ADDR_MINUTES, 32'h0, 32'hFF);
        wr(ADDR_CONTROL, 32'h00);
        rd(ADDR_HOURS, 32'h0, 32'hFF);
        for (i = 0; i < 3; i++) wr(ta[i], {24'h0, tm[i]});
        wr(ADDR_HOURS, {24'h0, HOUR_DAY_MAX});
        wr(ADDR_CONTROL, 32'h41);
        repeat (20) @(posedge hclk);
        rd(ADDR_HOURS, 32'h0, 32'hFF);
        wr(ADDR_SECONDS, 32'h20);
        rd(ADDR_SECONDS, 32'h0, 32'hFF);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_CONTROL, 32'h01, 32'hFF);
        wr(ADDR_CONTROL, 32'h00);
        for (i = 0; i < 4; i++) rd(ta[i], 32'h0, 32'hFF);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_TARGET, 32'h3);
        wr(ADDR_CONTROL, 32'h0B);
        repeat (60) @(posedge hclk);
        rd(ADDR_CONTROL, 32'h0D, 32'hFF);
        rd(ADDR_INTERVAL, 32'h0, 32'hFF);
        flag(1'b0, 1'b1);
        flag(1'b1, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0);
        flag(1'b0, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h1);
        flag(1'b0, 1'b1);
        rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
        flag(1'b0, 1'b0);
        rd(ADDR_CONTROL, 32'h04, 32'h04);
        wr(ADDR_CONTROL, 32'h09);
        rd(ADDR_CONTROL, 32'h09, 32'hFF);
        flag(1'b1, 1'b0);
        wr(ADDR_CONTROL, 32'h00);
        wr(ADDR_TARGET, 32'h2);
        wr(ADDR_CONTROL, 32'h03);
        repeat (100) @(posedge hclk);
        rd(ADDR_CONTROL, 32'h07, 32'hFF);
        wr(ADDR_CONTROL, 32'h01);
        rd(ADDR_INTERVAL, 32'h0, 32'hFF);
        wr(ADDR_TARGET, 32'h0);
        // Only the seconds base rolls over within the wait.
        for (i = 1; i < 4; i++) begin
            wr(ADDR_CONTROL, 32'h00);
            wr(ADDR_CONTROL, (i << 4) | 32'h03);
            repeat (700) @(posedge hclk);
            rd(ADDR_CONTROL, (i << 4) | 32'h03 | (i == 1 ? 32'h4 : 32'h0),
               32'hFF);
        end
        // Fraction rollovers have left the sticky seconds status bit set.
        wr(ADDR_IRQ_MASK, 32'h2);
        flag(1'b0, 1'b1);
        rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
        end_sim;
    end
endmodule

`default_nettype wire
